/* pdm_power_down_ctrl.v */
// Power-down mode controller: sleep and standby sequencing
`timescale 1ns/1ns
`include "pdm_consts.vh"
module pdm_power_down_ctrl (
	input  wire                   clk,
	input  wire                   rstn,
	input  wire                   clkEn,
	// Register port
	input  wire [`PDM_ADDR_W-1:0] regAddr,
	input  wire [`PDM_DATA_W-1:0] regWrData,
	input  wire                   regWr,
	input  wire                   regRd,
	output wire [`PDM_DATA_W-1:0] regRdData,
	// CPU and watchdog side, same clock
	input  wire                   sleepExec,
	input  wire                   watchdogRunEnable,
	// Interrupt controller and DMAC, same clock
	input  wire                   irqReq,
	input  wire                   irqPeriphEnable,
	input  wire [`PDM_LVL_W-1:0]  irqLevel,
	input  wire [`PDM_LVL_W-1:0]  cpuMaskLevel,
	input  wire                   dmaAddrErr,
	// Pins, asynchronous to clk
	input  wire                   nmiPin,
	input  wire                   powerOnResetPinN,
	// Power-down controls
	output wire                   cpuHalt,
	output wire                   clkStop,
	output wire                   periphHalt,
	output wire                   portFloat,
	output wire                   sleepActive,
	output wire                   standbyActive,
	output wire                   porActive,
	// Exception requests towards the CPU
	output wire                   irqExcReq,
	output wire                   dmaErrExcReq,
	output wire                   nmiExcReq
);

	// Sequencing overview:
	// run -> sleep or standby on a SLEEP instruction, picked by
	//   standby_select as it stands when the instruction retires.
	// sleep -> run on a DMAC address error or an accepted interrupt.
	// standby -> run only on a rising NMI edge.
	// The power-on reset pin returns every mode to run.
	// Limitation: a wake pulse lasts one cycle; the CPU must not miss it.

	// Mode states
	// Code 2'b11 is never entered; the default branch steers it to run
	localparam [`PDM_MODE_W-1:0] ST_RUN     = 2'b00;
	localparam [`PDM_MODE_W-1:0] ST_SLEEP   = 2'b01;
	localparam [`PDM_MODE_W-1:0] ST_STANDBY = 2'b10;

	// Address match, used by both the write and the read decode
	function addrHit;
		input [`PDM_ADDR_W-1:0] addr;
		input [`PDM_ADDR_W-1:0] target;
		begin
			addrHit = (addr == target);
		end
	endfunction

	// Standby decode; steers clock stop, peripheral halt, port float
	// and the standby flag from one place
	function isStandby;
		input [`PDM_MODE_W-1:0] mode;
		begin
			isStandby = (mode == ST_STANDBY);
		end
	endfunction

	// Stored control bits and state
	reg                     standbySelect_ff;
	reg                     portFloatSelect_ff;
	reg [`PDM_MODE_W-1:0]   mode_ff;
	reg [`PDM_CAUSE_W-1:0]  wakeCause_ff;
	reg                     nmiPrev_ff;
	reg [`PDM_DATA_W-1:0]   regRdData_ff;
	reg                     cpuHalt_ff;
	reg                     clkStop_ff;
	reg                     periphHalt_ff;
	reg                     portFloat_ff;
	reg                     irqExcReq_ff;
	reg                     dmaErrExcReq_ff;
	reg                     nmiExcReq_ff;

	// Next values
	reg                     nxt_standbySelect;
	reg                     nxt_portFloatSelect;
	reg [`PDM_MODE_W-1:0]   nxt_mode;
	reg [`PDM_CAUSE_W-1:0]  nxt_wakeCause;
	reg                     nxt_irqExc;
	reg                     nxt_dmaErrExc;
	reg                     nxt_nmiExc;
	reg [`PDM_DATA_W-1:0]   nxt_regRdData;

	// Decoded strobes and pin levels
	wire                    sbcWr;
	wire                    sbcRd;
	wire                    statRd;
	wire                    irqAccept;
	wire                    nmiSync;
	wire                    porNSync;
	wire                    porNow;
	wire                    nmiRise;
	wire [`PDM_DATA_W-1:0]  sbcView;
	wire [`PDM_DATA_W-1:0]  statView;
	wire                    selSetRefused;
	wire                    fltSetRefused;

	// Pins come from outside the clock domain, so two flops first
	// Flops reset to the idle level, so rstn release makes no false edge
	pdm_sync2 #(
		.RST_VAL (`PDM_NMI_IDLE)
	) u_syncNmi (
		.clk     (clk),
		.rstn    (rstn),
		.clkEn   (clkEn),
		.asyncIn (nmiPin),
		.syncOut (nmiSync)
	);

	pdm_sync2 #(
		.RST_VAL (`PDM_PORN_IDLE)
	) u_syncPor (
		.clk     (clk),
		.rstn    (rstn),
		.clkEn   (clkEn),
		.asyncIn (powerOnResetPinN),
		.syncOut (porNSync)
	);

	// Interrupt acceptance against the CPU mask level
	pdm_irq_accept u_accept (
		.irqReq          (irqReq),
		.irqPeriphEnable (irqPeriphEnable),
		.irqLevel        (irqLevel),
		.cpuMaskLevel    (cpuMaskLevel),
		.irqAccept       (irqAccept)
	);

	// Power-on reset is a level taken from the synchronised pin
	assign porNow  = ~porNSync;

	// NMI is edge triggered; the previous sample is a second-stage copy
	assign nmiRise = nmiSync & ~nmiPrev_ff;

	// Register strobes; writes and reads at unmapped addresses do nothing
	// The full address must match, so no alias decodes to a register
	assign sbcWr  = regWr & addrHit(regAddr, `PDM_SBC_ADDR);
	assign sbcRd  = regRd & addrHit(regAddr, `PDM_SBC_ADDR);
	assign statRd = regRd & addrHit(regAddr, `PDM_STAT_ADDR);

	// Read view of standby_control with fixed reserved bits
	assign sbcView = {standbySelect_ff,
		portFloatSelect_ff,
		`PDM_RSV5_VAL,
		`PDM_RSV_LOW_VAL};

	// Read view of the mode status word
	assign statView = {`PDM_ST_PAD, wakeCause_ff, mode_ff};

	// Refused sets: only a 1 written while the watchdog runs is blocked.
	// Each bit is judged alone, so one refusal never hides the other.
	assign selSetRefused = watchdogRunEnable & regWrData[`PDM_SEL_BIT];
	assign fltSetRefused = watchdogRunEnable & regWrData[`PDM_FLT_BIT];

	// Control bit writes; a set is refused while the watchdog runs,
	// a clear is always allowed so software can back out of standby
	always @* begin
		nxt_standbySelect   = standbySelect_ff;
		nxt_portFloatSelect = portFloatSelect_ff;
		if (sbcWr) begin
			if (!selSetRefused) begin
				nxt_standbySelect = regWrData[`PDM_SEL_BIT];
			end
			if (!fltSetRefused) begin
				nxt_portFloatSelect = regWrData[`PDM_FLT_BIT];
			end
		end
	end

	// Mode sequencing; DMAC error outranks interrupts when both arrive
	always @* begin
		nxt_mode      = mode_ff;
		nxt_wakeCause = wakeCause_ff;
		nxt_irqExc    = 1'b0;
		nxt_dmaErrExc = 1'b0;
		nxt_nmiExc    = 1'b0;
		case (mode_ff)
			// Only a SLEEP instruction leaves run
			ST_RUN: begin
				if (sleepExec) begin
					if (standbySelect_ff) begin
						nxt_mode = ST_STANDBY;
					end else begin
						nxt_mode = ST_SLEEP;
					end
				end
			end
			ST_SLEEP: begin
				if (dmaAddrErr) begin
					nxt_mode      = ST_RUN;
					nxt_dmaErrExc = 1'b1;
					nxt_wakeCause = `PDM_CAUSE_DMA;
				end else if (irqAccept) begin
					nxt_mode      = ST_RUN;
					nxt_irqExc    = 1'b1;
					nxt_wakeCause = `PDM_CAUSE_IRQ;
				end
			end
			ST_STANDBY: begin
				// Ordinary interrupts and DMAC errors are ignored here
				if (nmiRise) begin
					nxt_mode      = ST_RUN;
					nxt_nmiExc    = 1'b1;
					nxt_wakeCause = `PDM_CAUSE_NMI;
				end
			end
			// Unused state code recovers to run instead of locking up
			default: begin
				nxt_mode = ST_RUN;
			end
		endcase
	end

	// Read data stand for one cycle after the strobe, zero otherwise
	// The status word at its own address is read only; writes miss it
	always @* begin
		nxt_regRdData = {`PDM_DATA_W{1'b0}};
		if (sbcRd) begin
			nxt_regRdData = sbcView;
		end else if (statRd) begin
			nxt_regRdData = statView;
		end
	end

	// Control register; power-on reset restores the reset value.
	// The pin reset comes through the synchroniser, so it clears the
	// bits on the third clock edge after the pin falls, like any other sync event.
	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			standbySelect_ff   <= `PDM_SEL_RESET;
			portFloatSelect_ff <= `PDM_FLT_RESET;
		end else if (clkEn) begin
			if (porNow) begin
				standbySelect_ff   <= `PDM_SEL_RESET;
				portFloatSelect_ff <= `PDM_FLT_RESET;
			end else begin
				standbySelect_ff   <= nxt_standbySelect;
				portFloatSelect_ff <= nxt_portFloatSelect;
			end
		end
	end

	// Mode state and wake cause; the reset pin wins over everything
	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			mode_ff      <= ST_RUN;
			wakeCause_ff <= `PDM_CAUSE_NONE;
		end else if (clkEn) begin
			if (porNow) begin
				mode_ff      <= ST_RUN;
				wakeCause_ff <= `PDM_CAUSE_NONE;
			end else begin
				mode_ff      <= nxt_mode;
				wakeCause_ff <= nxt_wakeCause;
			end
		end
	end

	// NMI history for edge detection, idle level after reset
	// Only the second stage is read here, never the first flop
	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			nmiPrev_ff <= `PDM_NMI_IDLE;
		end else if (clkEn) begin
			nmiPrev_ff <= nmiSync;
		end
	end

	// Exception request pulses, one cycle each
	// A pin reset in progress masks them, so no handler starts in reset
	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			irqExcReq_ff    <= 1'b0;
			dmaErrExcReq_ff <= 1'b0;
			nmiExcReq_ff    <= 1'b0;
		end else if (clkEn) begin
			irqExcReq_ff    <= nxt_irqExc & ~porNow;
			dmaErrExcReq_ff <= nxt_dmaErrExc & ~porNow;
			nmiExcReq_ff    <= nxt_nmiExc & ~porNow;
		end
	end

	// Power controls follow the next mode so they align with mode_ff.
	// This block must sit on an always-on clock: clkStop only gates
	// the CPU and peripheral clocks, not the clock of this controller.
	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			cpuHalt_ff    <= 1'b0;
			clkStop_ff    <= 1'b0;
			periphHalt_ff <= 1'b0;
			portFloat_ff  <= 1'b0;
		end else if (clkEn) begin
			if (porNow) begin
				cpuHalt_ff    <= 1'b0;
				clkStop_ff    <= 1'b0;
				periphHalt_ff <= 1'b0;
				portFloat_ff  <= 1'b0;
			end else begin
				cpuHalt_ff    <= (nxt_mode != ST_RUN);
				clkStop_ff    <= isStandby(nxt_mode);
				periphHalt_ff <= isStandby(nxt_mode);
				portFloat_ff  <= isStandby(nxt_mode) &
					portFloatSelect_ff;
			end
		end
	end

	// Registered read data
	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			regRdData_ff <= {`PDM_DATA_W{1'b0}};
		end else if (clkEn) begin
			regRdData_ff <= nxt_regRdData;
		end
	end

	// Outputs; mode flags decode the state flop directly
	// and so line up with the registered halt controls
	assign regRdData     = regRdData_ff;
	assign cpuHalt       = cpuHalt_ff;
	assign clkStop       = clkStop_ff;
	assign periphHalt    = periphHalt_ff;
	assign portFloat     = portFloat_ff;
	assign sleepActive   = (mode_ff == ST_SLEEP);
	assign standbyActive = isStandby(mode_ff);
	assign porActive     = porNow;
	assign irqExcReq     = irqExcReq_ff;
	assign dmaErrExcReq  = dmaErrExcReq_ff;
	assign nmiExcReq     = nmiExcReq_ff;

endmodule // pdm_power_down_ctrl

/* pdm_consts.vh */
// Constants and register map of the power-down mode controller
// Contract
// - SLEEP executed with standby_select at 0 enters sleep mode.
// - In sleep the CPU halts; peripherals and clock keep running.
// - SLEEP with standby_select at 1 enters standby; clock, CPU, peripherals halt.
// - Sleep ends on an interrupt, a DMAC address error or power-on reset.
// - Sleep ended by an accepted interrupt leads to interrupt exception processing.
// - Interrupts at or below the mask level, or peripheral-disabled, keep sleep.
// - A DMAC address error in sleep wakes and requests its exception processing.
// - Power-on reset pin driven low ends sleep mode.
// - Standby ends only on NMI or power-on reset.
// - standby_select cannot be set to 1 while watchdog_run_enable is 1.
// - port_float_select cannot be set to 1 while watchdog_run_enable is 1.
// - standby_select is bit 7; 0 selects sleep (reset), 1 selects standby.
// - port_float_select is bit 6; 0 holds ports, 1 floats them in standby.
// - standby_control is an 8-bit read/write register resetting to 1F hex.
// - Reserved bit 5 reads 0, bits 4 to 0 read 1; write zeros.
`ifndef PDM_CONSTS_VH
`define PDM_CONSTS_VH

// Bus widths
`define PDM_ADDR_W      32
`define PDM_DATA_W      8
`define PDM_LVL_W       4

// Register byte addresses
`define PDM_SBC_ADDR    32'hFFFF8614
`define PDM_STAT_ADDR   32'hFFFF8618

// standby_control layout
`define PDM_SBC_RESET   8'h1F
`define PDM_SEL_BIT     7
`define PDM_FLT_BIT     6
`define PDM_SEL_RESET   1'h0
`define PDM_FLT_RESET   1'h0
`define PDM_RSV5_VAL    1'h0
`define PDM_RSV_LOW_VAL 5'h1F

// Status register layout: pad, last wake cause, mode
`define PDM_ST_PAD      4'h0
`define PDM_CAUSE_W     2
`define PDM_MODE_W      2

// Wake cause codes
`define PDM_CAUSE_NONE  2'h0
`define PDM_CAUSE_IRQ   2'h1
`define PDM_CAUSE_DMA   2'h2
`define PDM_CAUSE_NMI   2'h3

// Idle levels of synchronised pins
`define PDM_PORN_IDLE   1'h1
`define PDM_NMI_IDLE    1'h0

`endif

/* pdm_sync2.v */
// Two-flop synchroniser for asynchronous pin inputs
`timescale 1ns/1ns
module pdm_sync2 #(
	parameter RST_VAL = 1'b0
) (
	input  wire clk,
	input  wire rstn,
	input  wire clkEn,
	input  wire asyncIn,
	output wire syncOut
);

	reg stage1_ff;
	reg stage2_ff;

	// First stage feeds only the second; nothing else may look at it
	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			stage1_ff <= RST_VAL;
			stage2_ff <= RST_VAL;
		end else if (clkEn) begin
			stage1_ff <= asyncIn;
			stage2_ff <= stage1_ff;
		end
	end

	assign syncOut = stage2_ff;

endmodule // pdm_sync2

/* pdm_irq_accept.v */
// Decides whether a pending interrupt may be accepted by the CPU
`timescale 1ns/1ns
`include "pdm_consts.vh"
module pdm_irq_accept (
	input  wire                  irqReq,
	input  wire                  irqPeriphEnable,
	input  wire [`PDM_LVL_W-1:0] irqLevel,
	input  wire [`PDM_LVL_W-1:0] cpuMaskLevel,
	output wire                  irqAccept
);

	// Strictly above the mask level and enabled at the source
	assign irqAccept = irqReq & irqPeriphEnable &
		(irqLevel > cpuMaskLevel);

endmodule // pdm_irq_accept

/* pdm_power_down_ctrl_properties.sv */
// Port-level assertions of the power-down mode controller
`timescale 1ns/1ns
`include "pdm_consts.vh"
module pdm_power_down_ctrl_properties (
	input wire                   clk, rstn, clkEn, regWr, regRd,
	input wire [`PDM_ADDR_W-1:0] regAddr,
	input wire [`PDM_DATA_W-1:0] regWrData, regRdData,
	input wire                   sleepExec, watchdogRunEnable, irqReq,
	input wire                   irqPeriphEnable, dmaAddrErr, nmiPin,
	input wire [`PDM_LVL_W-1:0]  irqLevel, cpuMaskLevel,
	input wire                   powerOnResetPinN, cpuHalt, clkStop,
	input wire                   periphHalt, portFloat, sleepActive,
	input wire                   standbyActive, porActive, irqExcReq,
	input wire                   dmaErrExcReq, nmiExcReq
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rstn);
	// A pin reset in flight overrides every mode step, so steps skip it
	wire calm = clkEn && !porActive && powerOnResetPinN;
	wire run = !sleepActive && !standbyActive;
	wire irqOk = irqReq && irqPeriphEnable && (irqLevel > cpuMaskLevel);
	sequence quietPins; (!nmiPin && powerOnResetPinN)[*3]; endsequence
	sequence inSleep; sleepActive && calm && !dmaAddrErr; endsequence

	enter_power_down_a: assert property (run && sleepExec && calm |=>
		cpuHalt && (sleepActive ^ standbyActive)) else $error("no entry");
	sleep_clock_runs_a: assert property (sleepActive |-> cpuHalt &&
		!clkStop && !periphHalt && !portFloat) else $error("sleep halts");
	standby_halts_all_a: assert property (standbyActive |->
		cpuHalt && clkStop && periphHalt) else $error("standby halts");
	float_in_standby_a: assert property (portFloat |->
		standbyActive) else $error("float outside standby");
	irq_wakes_sleep_a: assert property (inSleep ##0 irqOk |=>
		!sleepActive && !cpuHalt && irqExcReq) else $error("irq wake");
	masked_keeps_sleep_a: assert property (inSleep ##0 !irqOk |=>
		sleepActive && !irqExcReq) else $error("sleep left");
	dma_wakes_sleep_a: assert property (sleepActive && dmaAddrErr && calm
		|=> !sleepActive && dmaErrExcReq) else $error("dma wake");
	standby_holds_a: assert property (quietPins ##0 standbyActive &&
		calm |=> standbyActive) else $error("standby left");
	nmi_wakes_a: assert property (standbyActive && calm && $rose(nmiPin)
		|-> ##[2:4] (nmiExcReq && !cpuHalt)) else $error("nmi wake");
	por_clears_modes_a: assert property (porActive && clkEn |=>
		!sleepActive && !standbyActive && !cpuHalt) else $error("pin reset");
	fixed_bits_a: assert property (regRd && clkEn &&
		regAddr == `PDM_SBC_ADDR |=> regRdData[5:0] == 6'h1F)
		else $error("reserved bits");
endmodule // pdm_power_down_ctrl_properties

bind pdm_power_down_ctrl pdm_power_down_ctrl_properties chk_u (
	.clk(clk), .rstn(rstn), .clkEn(clkEn), .regWr(regWr), .regRd(regRd),
	.regAddr(regAddr), .regWrData(regWrData), .regRdData(regRdData),
	.sleepExec(sleepExec), .watchdogRunEnable(watchdogRunEnable),
	.irqReq(irqReq), .irqPeriphEnable(irqPeriphEnable),
	.dmaAddrErr(dmaAddrErr), .nmiPin(nmiPin), .irqLevel(irqLevel),
	.cpuMaskLevel(cpuMaskLevel), .powerOnResetPinN(powerOnResetPinN),
	.cpuHalt(cpuHalt), .clkStop(clkStop), .periphHalt(periphHalt),
	.portFloat(portFloat), .sleepActive(sleepActive),
	.standbyActive(standbyActive), .porActive(porActive),
	.irqExcReq(irqExcReq), .dmaErrExcReq(dmaErrExcReq),
	.nmiExcReq(nmiExcReq));

/* pdm_irq_source.sv */
// Interrupt source model that holds its request until it is taken
`timescale 1ns/1ns
module pdm_irq_source (
	input  wire clk,
	input  wire rstn,
	input  wire raise,
	input  wire accepted,
	output reg  irqReq
);
	// Drops for one cycle once the exception is taken; it comes back while raise stays high
	always @(posedge clk or negedge rstn) begin
		if (!rstn)
			irqReq <= 1'b0;
		else
			irqReq <= raise & ~accepted;
	end
endmodule // pdm_irq_source

/* test_power_down_mode_control.sv */
// Self-checking bench of the power-down mode controller
`timescale 1ns/1ns
`include "pdm_consts.vh"
module test_power_down_mode_control;
	reg                    clk, rstn, regWr, regRd, sleepExec, wdtRun;
	reg                    irqEn, dmaErr, nmiPin, porPinN, raise, acc;
	reg  [`PDM_ADDR_W-1:0] regAddr;
	reg  [`PDM_DATA_W-1:0] regWrData, sbcExp;
	reg  [`PDM_LVL_W-1:0]  irqLevel, maskLevel;
	reg  [11:0]            r;
	wire [`PDM_DATA_W-1:0] regRdData;
	wire                   irqReq, cpuHalt, clkStop, periphHalt, portFloat;
	wire                   sleepActive, standbyActive, porActive;
	wire                   irqExcReq, dmaErrExcReq, nmiExcReq;
	integer                failures, checkCount, i;

	pdm_power_down_ctrl dut_u (.clk(clk), .rstn(rstn), .clkEn(1'b1),
		.regAddr(regAddr), .regWrData(regWrData), .regWr(regWr),
		.regRd(regRd), .regRdData(regRdData), .sleepExec(sleepExec),
		.watchdogRunEnable(wdtRun), .irqReq(irqReq),
		.irqPeriphEnable(irqEn), .irqLevel(irqLevel),
		.cpuMaskLevel(maskLevel), .dmaAddrErr(dmaErr), .nmiPin(nmiPin),
		.powerOnResetPinN(porPinN), .cpuHalt(cpuHalt), .clkStop(clkStop),
		.periphHalt(periphHalt), .portFloat(portFloat),
		.sleepActive(sleepActive), .standbyActive(standbyActive),
		.porActive(porActive), .irqExcReq(irqExcReq),
		.dmaErrExcReq(dmaErrExcReq), .nmiExcReq(nmiExcReq));
	pdm_irq_source src_u (.clk(clk), .rstn(rstn), .raise(raise),
		.accepted(irqExcReq), .irqReq(irqReq));

	// Expected register: a set is refused while the watchdog runs
	function [7:0] sbcNext(input [7:0] old, input [7:0] d, input w);
		sbcNext = {w ? old[7:6] & d[7:6] : d[7:6], 6'h1F};
	endfunction
	task chk(input [8*10:1] what, input [7:0] exp, input [7:0] got);
		begin
			checkCount = checkCount + 1;
			if (got !== exp) begin
				failures = failures + 1;
				$display("ERROR %0s expected %h seen %h", what, exp, got);
			end
		end
	endtask
	task rd(input [31:0] a, input [7:0] exp);
		begin
			@(posedge clk);
			regAddr <= a;
			regRd <= 1'b1;
			@(posedge clk);
			regRd <= 1'b0;
			#1 chk("read data", exp, regRdData);
		end
	endtask
	// Write then read back, so a refused set shows at once
	task wrChk(input [7:0] d, input w);
		begin
			@(posedge clk);
			regAddr <= `PDM_SBC_ADDR;
			regWrData <= d;
			wdtRun <= w;
			regWr <= 1'b1;
			@(posedge clk);
			regWr <= 1'b0;
			sbcExp = sbcNext(sbcExp, d, w);
			rd(`PDM_SBC_ADDR, sbcExp);
		end
	endtask
	task slp;
		begin
			@(posedge clk);
			sleepExec <= 1'b1;
			@(posedge clk);
			sleepExec <= 1'b0;
			#1;
		end
	endtask
	task conclude;
		begin
			if (failures == 0 && checkCount > 0)
				$display("Testbench passed");
			else
				$display("Testbench failed");
			$finish;
		end
	endtask

	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	// Whole run is a few hundred cycles; this bound only catches hangs
	initial begin
		#40000;
		failures = failures + 1;
		conclude;
	end
	initial begin
		{rstn, regWr, regRd, sleepExec, wdtRun, irqEn, dmaErr, raise} = 8'h00;
		{nmiPin, porPinN, regAddr, regWrData} = {2'h1, `PDM_SBC_ADDR, 8'h00};
		{irqLevel, maskLevel, failures, checkCount} = 0;
		sbcExp = `PDM_SBC_RESET;
		i = $urandom(32'h275C6E4A);
		repeat (20) @(posedge clk);
		rstn <= 1'b1;
		rd(`PDM_SBC_ADDR, 8'h1F);
		rd(`PDM_SBC_ADDR + 32'h1, 8'h00);
		// Reserved bits are always written as zero
		wrChk(8'hC0, 1'b1);
		wrChk(8'hC0, 1'b0);
		wrChk(8'h00, 1'b1);
		for (i = 0; i < 8; i = i + 1)
			wrChk($urandom & 32'hC0, $urandom);
		wrChk(8'h00, 1'b0);
		// Equal level, then disabled source, then random pairs
		for (i = 0; i < 14; i = i + 1) begin
			slp;
			chk("sleep", 8'h03, {clkStop, periphHalt, cpuHalt, sleepActive});
			r = $urandom;
			@(posedge clk);
			irqLevel <= (i == 0) ? 4'h5 : (i == 1) ? 4'h6 : r[3:0];
			maskLevel <= (i < 2) ? 4'h5 : r[7:4];
			irqEn <= (i == 1) ? 1'b0 : r[8];
			raise <= 1'b1;
			repeat (2) @(posedge clk);
			#1 acc = irqEn && (irqLevel > maskLevel);
			chk("irq wake", {acc, !acc}, {irqExcReq, sleepActive});
			@(posedge clk);
			raise <= 1'b0;
		end
		slp;
		@(posedge clk);
		dmaErr <= 1'b1;
		@(posedge clk);
		dmaErr <= 1'b0;
		#1 chk("dma wake", 8'h02, {dmaErrExcReq, sleepActive});
		rd(`PDM_STAT_ADDR, {`PDM_ST_PAD, `PDM_CAUSE_DMA, 2'h0});
		wrChk(8'hC0, 1'b0);
		slp;
		chk("standby", 8'h1F, {clkStop, periphHalt, cpuHalt, portFloat, standbyActive});
		@(posedge clk);
		{dmaErr, raise, irqEn, irqLevel, maskLevel} <= {3'h7, 8'hF0};
		repeat (3) @(posedge clk);
		{dmaErr, raise} <= 2'h0;
		#1 chk("no wake", 8'h01, standbyActive);
		rd(`PDM_STAT_ADDR, {`PDM_ST_PAD, `PDM_CAUSE_DMA, 2'h2});
		@(posedge clk);
		nmiPin <= 1'b1;
		i = 0;
		while (nmiExcReq !== 1'b1 && i < 6) begin
			@(posedge clk);
			#1 i = i + 1;
		end
		chk("nmi wake", 8'h01, {standbyActive, cpuHalt, nmiExcReq});
		@(posedge clk);
		nmiPin <= 1'b0;
		rd(`PDM_STAT_ADDR, {`PDM_ST_PAD, `PDM_CAUSE_NMI, 2'h0});
		wrChk(8'h40, 1'b0);
		slp;
		@(posedge clk);
		porPinN <= 1'b0;
		repeat (5) @(posedge clk);
		#1 chk("pin reset", 8'h04, {porActive, sleepActive, cpuHalt});
		@(posedge clk);
		porPinN <= 1'b1;
		repeat (4) @(posedge clk);
		rd(`PDM_SBC_ADDR, 8'h1F);
		rd(`PDM_STAT_ADDR, {`PDM_ST_PAD, `PDM_CAUSE_NONE, 2'h0});
		conclude;
	end
endmodule // test_power_down_mode_control
